// ---- hdl/phy_ext_consts.vh ----
// register numbers, field positions and reset values for the extended control and quick status slice
`ifndef PHY_EXT_CONSTS_VH
`define PHY_EXT_CONSTS_VH
`define REG_PARTNER_NP      5'h08
`define REG_RSVD_LO         5'h09
`define REG_RSVD_HI         5'h0F
`define REG_EXT_CTRL        5'h10
`define REG_QUICK_STAT      5'h11
`define NP_CODE_HI          3
`define NP_CODE_LO          0
`define EC_OVR_WE           15
`define EC_ADDR_HI          10
`define EC_ADDR_LO          6
`define EC_SCR_TEST         5
`define EC_NRZI             3
`define EC_TX_INVALID       2
`define EC_SCR_DIS          0
`define QS_RATE             15
`define QS_DUPLEX           14
`define QS_PROG2            13
`define QS_PROG1            12
`define EC_RESET            16'h0008
`define NP_CODE_RESET       4'h0
`define PROG_RESET          2'h0
`endif

// ---- hdl/phy_ext_control_quick_status.v ----
// management register slice: partner next-page code, reserved 9..15, extended control, quick status top
`timescale 1ns/1ps
`default_nettype none
`include "phy_ext_consts.vh"

// Operation
// - register 8 low nibble: read-only partner code bits, zero at reset
// - registers 9 to 15 reserved, read as zero, writes ignored
// - extended control bit 15 override write enable, resets zero, self-clears after use
// - quick status bit 15 reports rate: zero 10 Mbps, one 100 Mbps
// - quick status bit 14 reports duplex, one full, zero half
// - quick status bits 13:12 latched negotiation progress, reset zero
module phy_ext_control_quick_status (
  // clock and reset
  input  wire        CLK,
  input  wire        RST,
  // management register port
  input  wire [4:0]  REG_ADDR,
  input  wire        REG_WR,
  input  wire [15:0] REG_WDATA,
  output reg  [15:0] REG_RDATA,
  // status from the physical layer core
  input  wire [3:0]  NP_CODE_IN,
  input  wire        NP_CODE_LOAD,
  input  wire        RATE_100,
  input  wire        FULL_DUPLEX,
  input  wire [1:0]  PROG_IN,
  input  wire        PROG_LOAD,
  input  wire [4:0]  ADDR_STRAP,
  input  wire        OVR_TAKEN,
  // control out to the physical layer core
  output wire        OVR_WRITE_EN,
  output wire        SCR_TEST,
  output wire        NRZI_EN,
  output wire        TX_INVALID,
  output wire        SCR_DISABLE
);

  // reset image of the extended control word, taken apart per field
  localparam [15:0] EC_RST_WORD  = `EC_RESET;
  localparam [0:0]  OVR_RST      = EC_RST_WORD[`EC_OVR_WE];
  localparam [0:0]  SCR_TEST_RST = EC_RST_WORD[`EC_SCR_TEST];
  localparam [0:0]  NRZI_RST     = EC_RST_WORD[`EC_NRZI];
  localparam [0:0]  TX_INV_RST   = EC_RST_WORD[`EC_TX_INVALID];
  localparam [0:0]  SCR_DIS_RST  = EC_RST_WORD[`EC_SCR_DIS];

  // status latches and strap capture
  reg  [3:0]  np_code_r;
  reg  [1:0]  prog_r;
  reg  [4:0]  addr_r;
  reg         strap_done_r;
  // extended control flops
  reg         ovr_r;
  reg         scr_test_r;
  reg         nrzi_r;
  reg         tx_inv_r;
  reg         scr_dis_r;
  // read path
  reg  [15:0] np_word;
  reg  [15:0] ec_word;
  reg  [15:0] qs_word;
  reg  [15:0] rdata_nxt;
  // register number decode
  wire        sel_np;
  wire        sel_rsvd;
  wire        sel_ec;
  wire        sel_qs;
  wire        wr_ec;

  ////////////////////////////////////////////////////////////////////////////////
  // register number decode; the selects are one-hot by construction
  assign sel_np   = (REG_ADDR == `REG_PARTNER_NP);
  assign sel_rsvd = (REG_ADDR >= `REG_RSVD_LO) && (REG_ADDR <= `REG_RSVD_HI);
  assign sel_ec   = (REG_ADDR == `REG_EXT_CTRL);
  assign sel_qs   = (REG_ADDR == `REG_QUICK_STAT);
  // only the extended control register has writable bits; writes anywhere else are dropped
  assign wr_ec    = REG_WR && sel_ec;

  ////////////////////////////////////////////////////////////////////////////////
  // control levels to the core come straight from flops, never from the write data
  assign OVR_WRITE_EN = ovr_r;
  assign SCR_TEST     = scr_test_r;
  assign NRZI_EN      = nrzi_r;
  assign TX_INVALID   = tx_inv_r;
  assign SCR_DISABLE  = scr_dis_r;

  ////////////////////////////////////////////////////////////////////////////////
  // received partner code and progress monitor latches
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      np_code_r <= `NP_CODE_RESET;
    end else if (NP_CODE_LOAD) begin
      np_code_r <= NP_CODE_IN;
    end
  end

  // progress bits hold between load pulses, so a slow poll still sees the last stage
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      prog_r <= `PROG_RESET;
    end else if (PROG_LOAD) begin
      prog_r <= PROG_IN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // strap capture: taken once after reset release, never inside the reset branch
  // later strap changes are ignored until the next reset
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      addr_r       <= 5'h00;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      addr_r       <= ADDR_STRAP;
      strap_done_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // override write enable: set by the management side, cleared by the core once applied
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      ovr_r <= OVR_RST;
    end else if (wr_ec) begin
      // a new write of one wins over the self-clear in the same cycle
      ovr_r <= REG_WDATA[`EC_OVR_WE];
    end else if (OVR_TAKEN) begin
      ovr_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // plain read-write fields, one flop each; none of them has side effects
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      scr_test_r <= SCR_TEST_RST;
    end else if (wr_ec) begin
      scr_test_r <= REG_WDATA[`EC_SCR_TEST];
    end
  end

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      nrzi_r <= NRZI_RST;
    end else if (wr_ec) begin
      nrzi_r <= REG_WDATA[`EC_NRZI];
    end
  end

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      tx_inv_r <= TX_INV_RST;
    end else if (wr_ec) begin
      tx_inv_r <= REG_WDATA[`EC_TX_INVALID];
    end
  end

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      scr_dis_r <= SCR_DIS_RST;
    end else if (wr_ec) begin
      scr_dis_r <= REG_WDATA[`EC_SCR_DIS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read words, built field by field; reserved and out-of-slice bits stay zero
  always @* begin
    np_word                          = 16'h0000;
    np_word[`NP_CODE_HI:`NP_CODE_LO] = np_code_r;
  end

  always @* begin
    ec_word                          = 16'h0000;
    ec_word[`EC_OVR_WE]              = ovr_r;
    ec_word[`EC_ADDR_HI:`EC_ADDR_LO] = addr_r;
    ec_word[`EC_SCR_TEST]            = scr_test_r;
    ec_word[`EC_NRZI]                = nrzi_r;
    ec_word[`EC_TX_INVALID]          = tx_inv_r;
    ec_word[`EC_SCR_DIS]             = scr_dis_r;
  end

  // rate and duplex are live levels; only the progress field is latched
  always @* begin
    qs_word                          = 16'h0000;
    qs_word[`QS_RATE]                = RATE_100;
    qs_word[`QS_DUPLEX]              = FULL_DUPLEX;
    qs_word[`QS_PROG2:`QS_PROG1]     = prog_r;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read mux, registered so data appears one cycle after the address
  // the selects are one-hot, so the order of the tests does not matter
  always @* begin
    rdata_nxt = 16'h0000;
    if (sel_np) begin
      rdata_nxt = np_word;
    end else if (sel_ec) begin
      rdata_nxt = ec_word;
    end else if (sel_qs) begin
      rdata_nxt = qs_word;
    end else if (sel_rsvd) begin
      // reserved numbers have no function; zero keeps a blind poll harmless
      rdata_nxt = 16'h0000;
    end else begin
      // numbers owned by other slices are not answered here
      rdata_nxt = 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one flop stage on the read data so the bus sees a settled word at each edge
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      REG_RDATA <= 16'h0000;
    end else begin
      REG_RDATA <= rdata_nxt;
    end
  end

endmodule
`default_nettype wire

// ---- tb/phy_ext_chk.sv ----
// port assertions for the register slice
`timescale 1ns/1ps
`default_nettype none
module phy_ext_chk (
  input wire logic CLK, RST, REG_WR, RATE_100, FULL_DUPLEX, PROG_LOAD, OVR_TAKEN, OVR_WRITE_EN, NRZI_EN,
  input wire logic [4:0] REG_ADDR,
  input wire logic [1:0] PROG_IN,
  input wire logic [15:0] REG_WDATA, REG_RDATA
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  wire w16 = REG_WR && REG_ADDR == 5'h10;
  np_high_a: assert property (REG_ADDR == 5'h08 |=> REG_RDATA[15:4] == 0) else $error("np");
  rsvd_zero_a: assert property (REG_ADDR inside {[9:15]} |=> REG_RDATA == 0) else $error("rsvd");
  ovr_clear_a: assert property (OVR_TAKEN && !w16 |=> !OVR_WRITE_EN) else $error("ovr");
  rate_bit_a: assert property (REG_ADDR == 5'h11 |=> REG_RDATA[15] == $past(RATE_100)) else $error("rate");
  dup_bit_a: assert property (REG_ADDR == 5'h11 |=> REG_RDATA[14] == $past(FULL_DUPLEX)) else $error("dup");
  prog_hold_a: assert property (PROG_LOAD ##1 REG_ADDR == 5'h11 |=>
    REG_RDATA[13:12] == $past(PROG_IN, 2)) else $error("prog");
  ctrl_wr_a: assert property (w16 |=>
    OVR_WRITE_EN == $past(REG_WDATA[15]) && NRZI_EN == $past(REG_WDATA[3])) else $error("ctrl");
  c1: cover property (w16 && REG_WDATA[15]);
  c2: cover property (OVR_TAKEN);
  c3: cover property (PROG_LOAD);
endmodule
`default_nettype wire

// ---- tb/phy_core_model.sv ----
// core stand-in that acknowledges an override
`timescale 1ns/1ps
`default_nettype none
module phy_core_model (
  input wire logic clk, rst, ovr_en,
  output logic taken
);
  // acknowledge a cycle late, as a real core needs time to apply it
  always @(posedge clk or posedge rst)
    if (rst) taken <= 1'b0;
    else taken <= ovr_en & ~taken;
endmodule
`default_nettype wire

// ---- tb/phy_ext_control_quick_status_bench.sv ----
// self-checking bench for the register slice
`timescale 1ns/1ps
`default_nettype none
module phy_ext_control_quick_status_bench;
  logic clk = 0, rst = 1, wr = 0, npl = 0, r100 = 1, fd = 1, pl = 0, tk, ov, st, nz, ti, sd;
  logic [4:0] a = 0, strap = 5'h15;
  logic [15:0] wd = 0, rd;
  logic [3:0] np = 4'h9;
  logic [1:0] pg = 2'h2;
  int failures = 0, checks_done = 0;
  phy_ext_control_quick_status dut (.CLK(clk), .RST(rst), .REG_ADDR(a), .REG_WR(wr), .REG_WDATA(wd),
    .REG_RDATA(rd), .NP_CODE_IN(np), .NP_CODE_LOAD(npl), .RATE_100(r100), .FULL_DUPLEX(fd), .PROG_IN(pg),
    .PROG_LOAD(pl), .ADDR_STRAP(strap), .OVR_TAKEN(tk), .OVR_WRITE_EN(ov), .SCR_TEST(st), .NRZI_EN(nz),
    .TX_INVALID(ti), .SCR_DISABLE(sd));
  phy_core_model core (.clk(clk), .rst(rst), .ovr_en(ov), .taken(tk));
  initial forever #5 clk = ~clk;
  task chk(input string n, input logic [15:0] s, e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task rdc(input logic [4:0] ad, input logic [15:0] m, e, input string n);
    @(negedge clk) a = ad;
    @(negedge clk) chk(n, rd & m, e);
  endtask
  task wrt(input logic [4:0] ad, input logic [15:0] d);
    @(negedge clk) a = ad;
    wd = d;
    wr = 1;
    @(negedge clk) wr = 0;
  endtask
  task t_regs;
    chk("ctl rst", {st, nz, ti, sd}, 4'h4);
    rdc(5'h10, 16'hffff, 16'h0548, "ctl rst");
    wrt(5'h10, 16'h7fff);
    rdc(5'h10, 16'hffff, 16'h056d, "ctl wr");
    chk("ctl pins", {st, nz, ti, sd}, 4'hf);
    wrt(5'h0c, 16'hffff);
    rdc(5'h0c, 16'hffff, 16'h0000, "rsvd");
    $display("regs done");
  endtask
  task t_ovr;
    wrt(5'h10, 16'h8000);
    chk("ovr set", ov, 1);
    repeat (2) @(negedge clk);
    chk("ovr clr", {ov, nz}, 0);
    $display("override done");
  endtask
  task t_stat;
    rdc(5'h11, 16'hf000, 16'hc000, "qs rst");
    @(negedge clk) npl = 1;
    pl = 1;
    r100 = 0;
    fd = 0;
    @(negedge clk) npl = 0;
    pl = 0;
    pg = 0;
    np = 0;
    @(negedge clk) chk("qs", rd & 16'hf000, 16'h2000);
    wrt(5'h08, 16'hffff);
    rdc(5'h08, 16'hffff, 16'h0009, "np");
    $display("status done");
  endtask
  task t_rst;
    @(negedge clk) rst = 1;
    strap = 5'h0a;
    @(negedge clk) rst = 0;
    chk("rst pins", {ov, st, nz, ti, sd}, 16'h0004);
    rdc(5'h10, 16'hffff, 16'h0288, "rst ctl");
    rdc(5'h11, 16'h3000, 16'h0000, "rst prog");
    rdc(5'h08, 16'hffff, 16'h0000, "rst np");
    $display("reset done");
  endtask
  task tally_and_finish;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rst = 0;
    t_regs;
    t_ovr;
    t_stat;
    t_rst;
    tally_and_finish;
  end
  // a hang counts as a mismatch
  initial begin
    repeat (500) @(posedge clk);
    failures++;
    tally_and_finish;
  end
endmodule
bind phy_ext_control_quick_status phy_ext_chk chk_i (.*);
`default_nettype wire
